// File: sfb_bank_zero_map.sv
/*
  bank 0 special function register file of an 8-bit controller core,
  reached over AXI4-Lite. assumes a data memory port on the same clock
  for indirect accesses, and a core that pulses pc_inc_i to step.
*/
`timescale 1ns/10ps

module sfb_bank_zero_map
  import sfb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [sfb_pkg::SFB_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [sfb_pkg::SFB_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic master_clear_pin_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic pc_inc_i,
  input wire logic [sfb_pkg::SFB_PA_W-1:0] port_a_pins_i,
  input wire logic [sfb_pkg::SFB_PB_W-1:0] port_b_pins_i,
  input wire logic [sfb_pkg::SFB_PC_PORT_W-1:0] port_c_pins_i,
  output logic [sfb_pkg::SFB_PA_W-1:0] port_a_latch_o,
  output logic [sfb_pkg::SFB_PB_W-1:0] port_b_latch_o,
  output logic [sfb_pkg::SFB_PC_PORT_W-1:0] port_c_latch_o,
  output logic [sfb_pkg::SFB_PC_W-1:0] pc_o,
  output logic bank_select_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [7:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i
);
  import sfb_pkg::*;

  // front end request
  logic fe_req;
  logic fe_we;
  logic fe_wen;
  logic [SFB_IDX_W-1:0] fe_idx;
  logic [7:0] fe_wdata;

  // answer back to front end
  logic ack_reg;
  logic [7:0] ack_data_reg;

  // synchronised pins
  logic [SFB_SYNC_W-1:0] sync_q;
  wire logic master_clear_pin_n_sync = sync_q[SFB_SYNC_W-1];
  wire logic [SFB_PA_W-1:0] pins_a = sync_q[SFB_PA_W-1:0];
  wire logic [SFB_PB_W-1:0] pins_b =
    sync_q[SFB_PA_W+SFB_PB_W-1:SFB_PA_W];
  wire logic [SFB_PC_PORT_W-1:0] pins_c =
    sync_q[SFB_SYNC_W-2:SFB_PA_W+SFB_PB_W];

  // register storage, one entry per index
  logic [7:0] sfr_q [SFB_NREG];

  // program counter and indirect sequencer
  logic [SFB_PC_W-1:0] pc_reg;
  logic [SFB_PC_W-1:0] pc_next;
  sfb_ind_state_t ind_reg;
  sfb_ind_state_t ind_next;
  logic mem_req_reg;
  logic mem_we_reg;
  logic [7:0] mem_addr_reg;
  logic [7:0] mem_wdata_reg;

  sfb_axil_front u_front (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .req_o(fe_req),
    .req_we_o(fe_we),
    .req_wen_o(fe_wen),
    .req_idx_o(fe_idx),
    .req_wdata_o(fe_wdata),
    .ack_i(ack_reg),
    .ack_rdata_i(ack_data_reg)
  );

  sfb_pin_sync #(
    .WIDTH(SFB_SYNC_W)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .async_i({master_clear_pin_n_i, port_c_pins_i, port_b_pins_i,
      port_a_pins_i}),
    .sync_o(sync_q)
  );

  // reset class: master clear or watchdog, the power-on reset is arst_n_i
  wire logic other_rst = ~master_clear_pin_n_sync | watchdog_timeout_i;

  // bank decode
  wire logic bank_hi = sfr_q[SFB_IDX_CPU_STATUS_FLAGS][SFB_ST_BANK_SEL];
  wire logic idx_common = SFB_COMMON[fe_idx];
  wire logic idx_live = ~bank_hi | idx_common;
  wire logic [7:0] rd_mask = idx_live ? SFB_RD_MASK[fe_idx] : 8'h00;

  // indirect decode
  wire logic [7:0] pointer = sfr_q[SFB_IDX_INDIRECT_POINTER];
  wire logic ind_hit = idx_live & (fe_idx == SFB_IDX_INDIRECT_DATA_PORT);
  wire logic ptr_zero = (pointer == 8'h00);
  wire logic ind_go = fe_req & ind_hit & ~ptr_zero & (~fe_we | fe_wen);
  wire logic ind_done = (ind_reg == SFB_IND_WAIT) & mem_ack_i;

  // direct write decode
  wire logic wr_hit = fe_req & fe_we & fe_wen & idx_live & ~ind_hit;
  wire logic pcl_wr = wr_hit & (fe_idx == SFB_IDX_PROGRAM_COUNTER_LOW);

  // direct read value; ports read pins, pc low reads the counter
  logic [7:0] rd_raw;
  always_comb
  begin
    case (fe_idx)
      SFB_IDX_PROGRAM_COUNTER_LOW: rd_raw = pc_reg[7:0];
      SFB_IDX_PORT_A_LATCH: rd_raw = {2'b00, pins_a};
      SFB_IDX_PORT_B_LATCH: rd_raw = pins_b;
      SFB_IDX_PORT_C_LATCH: rd_raw = pins_c;
      SFB_IDX_INDIRECT_DATA_PORT: rd_raw = 8'h00;
      default: rd_raw = sfr_q[fe_idx];
    endcase
  end
  wire logic [7:0] rd_val = fe_we ? 8'h00 : (rd_raw & rd_mask);

  // plain register entries
  for (genvar i = 0; i < SFB_NREG; i++)
  begin : g_reg
    logic [7:0] val_reg;
    logic [7:0] val_next;
    wire logic sel = wr_hit & (fe_idx == SFB_IDX_W'(i));
    wire logic [7:0] kept =
      (val_reg & SFB_KEEP[i]) | (SFB_POR_VAL[i] & ~SFB_KEEP[i]);
    wire logic [7:0] wr_val =
      (val_reg & ~SFB_WR_MASK[i]) | (fe_wdata & SFB_WR_MASK[i]);

    always_comb
    begin
      val_next = val_reg;
      if (other_rst)
      begin
        val_next = kept;
        if (i == int'(SFB_IDX_CPU_STATUS_FLAGS))
        begin
          val_next[SFB_ST_TIMEOUT] = ~watchdog_timeout_i;
          val_next[SFB_ST_POWER_DOWN] = 1'b1;
        end
      end
      else if (sel)
      begin
        val_next = wr_val;
      end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
      if (!arst_n_i)
        val_reg <= SFB_POR_VAL[i];
      else
        val_reg <= val_next;
    end

    assign sfr_q[i] = val_reg;
  end

  // program counter: latch write alone leaves it untouched
  wire logic [SFB_LATCH_W-1:0] pc_latch =
    sfr_q[SFB_IDX_PC_HIGH_LATCH][SFB_LATCH_W-1:0];
  always_comb
  begin
    pc_next = pc_reg;
    if (other_rst)
      pc_next = '0;
    else if (pcl_wr)
      pc_next = {pc_latch, fe_wdata};
    else if (pc_inc_i)
      pc_next = pc_reg + 1'b1;
  end

  // indirect sequencer
  always_comb
  begin
    ind_next = ind_reg;
    case (ind_reg)
      SFB_IND_IDLE: if (ind_go) ind_next = SFB_IND_WAIT;
      SFB_IND_WAIT: if (mem_ack_i) ind_next = SFB_IND_IDLE;
      default: ind_next = SFB_IND_IDLE;
    endcase
  end

  // direct requests answer next cycle, indirect ones the cycle after memory ack
  wire logic ack_next = (fe_req & ~ind_go) | ind_done;
  wire logic [7:0] ack_data_next =
    ind_done ? (mem_we_reg ? 8'h00 : mem_rdata_i) : rd_val;
  wire logic mem_req_next = ind_go | (mem_req_reg & ~mem_ack_i);

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pc_reg <= '0;
      ind_reg <= SFB_IND_IDLE;
      ack_reg <= 1'b0;
      ack_data_reg <= 8'h00;
      mem_req_reg <= 1'b0;
    end
    else
    begin
      pc_reg <= pc_next;
      ind_reg <= ind_next;
      ack_reg <= ack_next;
      ack_data_reg <= ack_data_next;
      mem_req_reg <= mem_req_next;
    end
  end

  // memory request payload, held while the request stands
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 8'h00;
      mem_wdata_reg <= 8'h00;
    end
    else if (ind_go)
    begin
      mem_we_reg <= fe_we;
      mem_addr_reg <= pointer;
      mem_wdata_reg <= fe_wdata;
    end
  end

  assign port_a_latch_o = sfr_q[SFB_IDX_PORT_A_LATCH][SFB_PA_W-1:0];
  assign port_b_latch_o = sfr_q[SFB_IDX_PORT_B_LATCH];
  assign port_c_latch_o = sfr_q[SFB_IDX_PORT_C_LATCH];
  assign pc_o = pc_reg;
  assign bank_select_o = bank_hi;
  assign mem_req_o = mem_req_reg;
  assign mem_we_o = mem_we_reg;
  assign mem_addr_o = mem_addr_reg;
  assign mem_wdata_o = mem_wdata_reg;
endmodule

// File: sfb_pkg.sv
/*
  constants, register map and reset tables of the bank 0 register file.
  assumes a 32-bit AXI4-Lite bus with one aligned word per register.
*/
package sfb_pkg;

  localparam int SFB_ADDR_W = 7;
  localparam int SFB_IDX_W = 5;
  localparam int SFB_NREG = 32;
  localparam int SFB_PC_W = 13;
  localparam int SFB_LATCH_W = 5;
  localparam int SFB_PA_W = 6;
  localparam int SFB_PB_W = 8;
  localparam int SFB_PC_PORT_W = 8;
  localparam int SFB_SYNC_W = 1 + SFB_PA_W + SFB_PB_W + SFB_PC_PORT_W;

  // register indices; byte address is four times the index
  localparam logic [4:0] SFB_IDX_INDIRECT_DATA_PORT = 5'h00;
  localparam logic [4:0] SFB_IDX_TIMER_ZERO_COUNT = 5'h01;
  localparam logic [4:0] SFB_IDX_PROGRAM_COUNTER_LOW = 5'h02;
  localparam logic [4:0] SFB_IDX_CPU_STATUS_FLAGS = 5'h03;
  localparam logic [4:0] SFB_IDX_INDIRECT_POINTER = 5'h04;
  localparam logic [4:0] SFB_IDX_PORT_A_LATCH = 5'h05;
  localparam logic [4:0] SFB_IDX_PORT_B_LATCH = 5'h06;
  localparam logic [4:0] SFB_IDX_PORT_C_LATCH = 5'h07;
  localparam logic [4:0] SFB_IDX_PC_HIGH_LATCH = 5'h0A;
  localparam logic [4:0] SFB_IDX_INTERRUPT_CONTROL = 5'h0B;
  localparam logic [4:0] SFB_IDX_PERIPHERAL_FLAGS_ONE = 5'h0C;
  localparam logic [4:0] SFB_IDX_PERIPHERAL_FLAGS_TWO = 5'h0D;
  localparam logic [4:0] SFB_IDX_TIMER_ONE_LOW = 5'h0E;
  localparam logic [4:0] SFB_IDX_TIMER_ONE_HIGH = 5'h0F;
  localparam logic [4:0] SFB_IDX_TIMER_ONE_CONTROL = 5'h10;
  localparam logic [4:0] SFB_IDX_TIMER_TWO_COUNT = 5'h11;
  localparam logic [4:0] SFB_IDX_TIMER_TWO_CONTROL = 5'h12;
  localparam logic [4:0] SFB_IDX_SYNC_SERIAL_BUFFER = 5'h13;
  localparam logic [4:0] SFB_IDX_SYNC_SERIAL_CONTROL = 5'h14;
  localparam logic [4:0] SFB_IDX_CAPTURE_ONE_LOW = 5'h15;
  localparam logic [4:0] SFB_IDX_CAPTURE_ONE_HIGH = 5'h16;
  localparam logic [4:0] SFB_IDX_CAPTURE_ONE_CONTROL = 5'h17;
  localparam logic [4:0] SFB_IDX_SERIAL_RECEIVE_CONTROL = 5'h18;
  localparam logic [4:0] SFB_IDX_SERIAL_TRANSMIT_HOLDING = 5'h19;
  localparam logic [4:0] SFB_IDX_SERIAL_RECEIVE_HOLDING = 5'h1A;
  localparam logic [4:0] SFB_IDX_CAPTURE_TWO_LOW = 5'h1B;
  localparam logic [4:0] SFB_IDX_CAPTURE_TWO_HIGH = 5'h1C;
  localparam logic [4:0] SFB_IDX_CAPTURE_TWO_CONTROL = 5'h1D;

  // status bit positions
  localparam int SFB_ST_BANK_SEL = 5;
  localparam int SFB_ST_TIMEOUT = 4;
  localparam int SFB_ST_POWER_DOWN = 3;

  localparam logic [1:0] SFB_RESP_OKAY = 2'b00;

  typedef logic [SFB_NREG-1:0][7:0] sfb_table_t;

  // bits that read back (zero elsewhere)
  localparam sfb_table_t SFB_RD_MASK = '{
    SFB_IDX_INDIRECT_DATA_PORT: 8'hFF, SFB_IDX_TIMER_ZERO_COUNT: 8'hFF,
    SFB_IDX_PROGRAM_COUNTER_LOW: 8'hFF, SFB_IDX_CPU_STATUS_FLAGS: 8'hFF,
    SFB_IDX_INDIRECT_POINTER: 8'hFF, SFB_IDX_PORT_A_LATCH: 8'h3F,
    SFB_IDX_PORT_B_LATCH: 8'hFF, SFB_IDX_PORT_C_LATCH: 8'hFF,
    SFB_IDX_PC_HIGH_LATCH: 8'h1F, SFB_IDX_INTERRUPT_CONTROL: 8'hFF,
    SFB_IDX_PERIPHERAL_FLAGS_ONE: 8'hFF, SFB_IDX_PERIPHERAL_FLAGS_TWO: 8'h01,
    SFB_IDX_TIMER_ONE_LOW: 8'hFF, SFB_IDX_TIMER_ONE_HIGH: 8'hFF,
    SFB_IDX_TIMER_ONE_CONTROL: 8'h3F, SFB_IDX_TIMER_TWO_COUNT: 8'hFF,
    SFB_IDX_TIMER_TWO_CONTROL: 8'h7F, SFB_IDX_SYNC_SERIAL_BUFFER: 8'hFF,
    SFB_IDX_SYNC_SERIAL_CONTROL: 8'hFF, SFB_IDX_CAPTURE_ONE_LOW: 8'hFF,
    SFB_IDX_CAPTURE_ONE_HIGH: 8'hFF, SFB_IDX_CAPTURE_ONE_CONTROL: 8'h3F,
    SFB_IDX_SERIAL_RECEIVE_CONTROL: 8'hF7,
    SFB_IDX_SERIAL_RECEIVE_HOLDING: 8'hFF,
    SFB_IDX_CAPTURE_TWO_LOW: 8'hFF, SFB_IDX_CAPTURE_TWO_HIGH: 8'hFF,
    SFB_IDX_CAPTURE_TWO_CONTROL: 8'h3F, default: 8'h00};

  // bits that software may write
  localparam sfb_table_t SFB_WR_MASK = '{
    SFB_IDX_TIMER_ZERO_COUNT: 8'hFF, SFB_IDX_CPU_STATUS_FLAGS: 8'hE7,
    SFB_IDX_INDIRECT_POINTER: 8'hFF, SFB_IDX_PORT_A_LATCH: 8'h3F,
    SFB_IDX_PORT_B_LATCH: 8'hFF, SFB_IDX_PORT_C_LATCH: 8'hFF,
    SFB_IDX_PC_HIGH_LATCH: 8'h1F, SFB_IDX_INTERRUPT_CONTROL: 8'hFF,
    SFB_IDX_PERIPHERAL_FLAGS_ONE: 8'hFF, SFB_IDX_PERIPHERAL_FLAGS_TWO: 8'h01,
    SFB_IDX_TIMER_ONE_LOW: 8'hFF, SFB_IDX_TIMER_ONE_HIGH: 8'hFF,
    SFB_IDX_TIMER_ONE_CONTROL: 8'h3F, SFB_IDX_TIMER_TWO_COUNT: 8'hFF,
    SFB_IDX_TIMER_TWO_CONTROL: 8'h7F, SFB_IDX_SYNC_SERIAL_BUFFER: 8'hFF,
    SFB_IDX_SYNC_SERIAL_CONTROL: 8'hFF, SFB_IDX_CAPTURE_ONE_LOW: 8'hFF,
    SFB_IDX_CAPTURE_ONE_HIGH: 8'hFF, SFB_IDX_CAPTURE_ONE_CONTROL: 8'h3F,
    SFB_IDX_SERIAL_RECEIVE_CONTROL: 8'hF1,
    SFB_IDX_SERIAL_TRANSMIT_HOLDING: 8'hFF,
    SFB_IDX_CAPTURE_TWO_LOW: 8'hFF, SFB_IDX_CAPTURE_TWO_HIGH: 8'hFF,
    SFB_IDX_CAPTURE_TWO_CONTROL: 8'h3F, default: 8'h00};

  // power-on / brown-out values; unknown bits come up as zero
  localparam sfb_table_t SFB_POR_VAL = '{
    SFB_IDX_CPU_STATUS_FLAGS: 8'h18, default: 8'h00};

  // bits kept through master clear and watchdog resets
  localparam sfb_table_t SFB_KEEP = '{
    SFB_IDX_TIMER_ZERO_COUNT: 8'hFF, SFB_IDX_CPU_STATUS_FLAGS: 8'h07,
    SFB_IDX_INDIRECT_POINTER: 8'hFF, SFB_IDX_PORT_A_LATCH: 8'h3F,
    SFB_IDX_PORT_B_LATCH: 8'hFF, SFB_IDX_PORT_C_LATCH: 8'hFF,
    SFB_IDX_INTERRUPT_CONTROL: 8'h01, SFB_IDX_TIMER_ONE_LOW: 8'hFF,
    SFB_IDX_TIMER_ONE_HIGH: 8'hFF, SFB_IDX_TIMER_ONE_CONTROL: 8'h3F,
    SFB_IDX_SYNC_SERIAL_BUFFER: 8'hFF, SFB_IDX_CAPTURE_ONE_LOW: 8'hFF,
    SFB_IDX_CAPTURE_ONE_HIGH: 8'hFF, SFB_IDX_SERIAL_RECEIVE_CONTROL: 8'h01,
    SFB_IDX_CAPTURE_TWO_LOW: 8'hFF, SFB_IDX_CAPTURE_TWO_HIGH: 8'hFF,
    default: 8'h00};

  // registers decoded in either bank
  localparam logic [SFB_NREG-1:0] SFB_COMMON = 32'h0000_0C1D;

  typedef enum logic [3:0] {
    SFB_FE_IDLE = 4'b0001,
    SFB_FE_BUSY = 4'b0010,
    SFB_FE_WRESP = 4'b0100,
    SFB_FE_RRESP = 4'b1000
  } sfb_fe_state_t;

  typedef enum logic [1:0] {
    SFB_IND_IDLE = 2'b01,
    SFB_IND_WAIT = 2'b10
  } sfb_ind_state_t;

endpackage

// File: sfb_pin_sync.sv
/*
  three-flop synchroniser; a bit changes once stages two and three agree.
  assumes inputs asynchronous to core_clk_i.
*/
`timescale 1ns/10ps
module sfb_pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] q_reg;
  wire logic [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
  wire logic [WIDTH-1:0] q_next = (s3_reg & agree) | (q_reg & ~agree);

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end
    else
    begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign sync_o = q_reg;
endmodule

// File: sfb_axil_front.sv
/*
  AXI4-Lite slave front end: turns one transfer at a time into a request
  with an acknowledge. assumes the register side acks each request once.
*/
`timescale 1ns/10ps
module sfb_axil_front
  import sfb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [sfb_pkg::SFB_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [sfb_pkg::SFB_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic req_o,
  output logic req_we_o,
  output logic req_wen_o,
  output logic [sfb_pkg::SFB_IDX_W-1:0] req_idx_o,
  output logic [7:0] req_wdata_o,
  input wire logic ack_i,
  input wire logic [7:0] ack_rdata_i
);
  sfb_fe_state_t st_reg, st_next;
  logic aw_full_reg, w_full_reg, ar_full_reg;
  logic [SFB_IDX_W-1:0] aw_idx_reg, ar_idx_reg;
  logic [7:0] w_data_reg;
  logic w_en_reg;
  logic req_reg, we_reg;
  logic [7:0] rdata_reg;

  wire logic idle = (st_reg == SFB_FE_IDLE);
  wire logic aw_take = s_axi_awvalid_i & ~aw_full_reg;
  wire logic w_take = s_axi_wvalid_i & ~w_full_reg;
  wire logic ar_take = s_axi_arvalid_i & ~ar_full_reg;
  // writes win when both are pending
  wire logic go_wr = idle & aw_full_reg & w_full_reg;
  wire logic go_rd = idle & ar_full_reg & ~go_wr;

  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      SFB_FE_IDLE: if (go_wr | go_rd) st_next = SFB_FE_BUSY;
      SFB_FE_BUSY: if (ack_i) st_next = we_reg ? SFB_FE_WRESP : SFB_FE_RRESP;
      SFB_FE_WRESP: if (s_axi_bready_i) st_next = SFB_FE_IDLE;
      SFB_FE_RRESP: if (s_axi_rready_i) st_next = SFB_FE_IDLE;
      default: st_next = SFB_FE_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_reg <= SFB_FE_IDLE;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      ar_full_reg <= 1'b0;
      aw_idx_reg <= '0;
      ar_idx_reg <= '0;
      w_data_reg <= '0;
      w_en_reg <= 1'b0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      aw_full_reg <= aw_full_reg ? ~go_wr : aw_take;
      w_full_reg <= w_full_reg ? ~go_wr : w_take;
      ar_full_reg <= ar_full_reg ? ~go_rd : ar_take;
      if (aw_take) aw_idx_reg <= s_axi_awaddr_i[SFB_ADDR_W-1:2];
      if (ar_take) ar_idx_reg <= s_axi_araddr_i[SFB_ADDR_W-1:2];
      if (w_take) w_data_reg <= s_axi_wdata_i[7:0];
      if (w_take) w_en_reg <= s_axi_wstrb_i[0];
      req_reg <= go_wr | go_rd;
      if (go_wr | go_rd) we_reg <= go_wr;
      if (ack_i) rdata_reg <= ack_rdata_i;
    end
  end

  assign s_axi_awready_o = ~aw_full_reg;
  assign s_axi_wready_o = ~w_full_reg;
  assign s_axi_arready_o = ~ar_full_reg;
  assign s_axi_bvalid_o = st_reg[2];
  assign s_axi_rvalid_o = st_reg[3];
  assign s_axi_bresp_o = SFB_RESP_OKAY;
  assign s_axi_rresp_o = SFB_RESP_OKAY;
  assign s_axi_rdata_o = {24'h00_0000, rdata_reg};
  assign req_o = req_reg;
  assign req_we_o = we_reg;
  assign req_wen_o = w_en_reg;
  assign req_idx_o = we_reg ? aw_idx_reg : ar_idx_reg;
  assign req_wdata_o = w_data_reg;
endmodule

// File: sfb_bank_zero_map_sva.sv
/*
  concurrent checks on the bank 0 register file ports.
  assumes it is bound onto the top module of the register file.
*/
`timescale 1ns/10ps
module sfb_bank_zero_map_sva
  import sfb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [sfb_pkg::SFB_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic master_clear_pin_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic pc_inc_i,
  input wire logic [sfb_pkg::SFB_PC_W-1:0] pc_o,
  input wire logic bank_select_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [7:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic mem_ack_i
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_quiet;
    !pc_inc_i && !watchdog_timeout_i && master_clear_pin_n_i;
  endsequence
  sequence s_latch_wr;
    s_axi_awvalid_i && s_axi_awready_o &&
      s_axi_awaddr_i[6:2] == SFB_IDX_PC_HIGH_LATCH ##0 s_quiet;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence

  a_latch_keeps_pc: assert property (
    s_latch_wr ##1 s_quiet [*6] |-> pc_o == $past(pc_o, 6))
    else $error("pc moved on a latch write");
  a_rdata_upper: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_write_okay: assert property (
    s_axi_bvalid_o |-> s_axi_bresp_o == SFB_RESP_OKAY)
    else $error("write response not okay");
  a_read_okay: assert property (
    s_axi_rvalid_o |-> s_axi_rresp_o == SFB_RESP_OKAY)
    else $error("read response not okay");
  a_wdog_pc_zero: assert property (
    watchdog_timeout_i |=> pc_o == '0)
    else $error("pc not cleared by watchdog");
  a_wdog_bank_zero: assert property (
    watchdog_timeout_i |=> !bank_select_o)
    else $error("bank select kept through watchdog");
  a_mem_req_hold: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) &&
    $stable(mem_we_o) && $stable(mem_wdata_o))
    else $error("memory request dropped or changed");
  a_mem_no_null: assert property (
    mem_req_o |-> mem_addr_o != 8'h00)
    else $error("memory cycle with null pointer");
  a_read_answered: assert property (
    s_read_taken |-> ##[1:40] s_axi_rvalid_o)
    else $error("read not answered");
endmodule

bind sfb_bank_zero_map sfb_bank_zero_map_sva sfb_bank_zero_map_sva_inst (.*);

// File: test_sfb_bank_zero_map.sv
/*
  self-checking bench for the bank 0 register file.
  assumes the design files and the checker are compiled first.
*/
`timescale 1ns/10ps
module test_sfb_bank_zero_map;
  import sfb_pkg::*;
  logic core_clk_i = 0, arst_n_i = 0, s_axi_awvalid_i = 0;
  logic s_axi_wvalid_i = 0, s_axi_bready_i = 0, s_axi_arvalid_i = 0;
  logic s_axi_rready_i = 0, master_clear_pin_n_i = 1, pc_inc_i = 0;
  logic watchdog_timeout_i = 0, mem_ack_i = 0;
  logic [6:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0;
  logic [3:0] s_axi_wstrb_i = 0;
  logic [5:0] port_a_pins_i = 0;
  logic [7:0] port_b_pins_i = 0, port_c_pins_i = 0, mem_rdata_i = 0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, bank_select_o, mem_req_o, mem_we_o, go;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [5:0] port_a_latch_o;
  logic [7:0] port_b_latch_o, port_c_latch_o, mem_addr_o, mem_wdata_o;
  logic [12:0] pc_o;
  logic [16:0] exp_mem = 0;
  logic [7:0] exp_q[$];
  logic [7:0] mem_byte = 0, r, e;
  logic [23:0] lat = 0;
  int bad_count = 0, tests_run = 0, mem_wait = 0, mem_cnt = 0;

  sfb_bank_zero_map sfb_bank_zero_map_inst (.*);

  always #2 core_clk_i = ~core_clk_i;

  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic rst_seq;
    arst_n_i <= 0;
    repeat (2) @(posedge core_clk_i);
    arst_n_i <= 1;
    repeat (4) @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    @(posedge core_clk_i);
    s_axi_awaddr_i <= {idx, 2'b00};
    s_axi_wdata_i <= {24'h0, d};
    s_axi_wstrb_i <= 4'h1;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    do
    begin
      @(posedge core_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 0;
  endtask

  task automatic rd(input logic [4:0] idx, input logic [7:0] ex);
    exp_q.push_back(ex);
    @(posedge core_clk_i);
    s_axi_araddr_i <= {idx, 2'b00};
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    do
    begin
      @(posedge core_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 0;
  endtask

  // read results taken off the note queue in order
  always @(posedge core_clk_i)
    if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i)
      check("rdata", s_axi_rdata_o, {24'h0, exp_q.pop_front()});

  // data memory stand-in; bus shows junk when not answering
  always @(posedge core_clk_i)
  begin
    go = mem_req_o === 1'b1 && !mem_ack_i && mem_cnt >= mem_wait;
    if (go)
      check("mem", {mem_we_o, mem_addr_o, mem_wdata_o & {8{mem_we_o}}},
        exp_mem);
    mem_cnt = (mem_req_o === 1'b1 && !mem_ack_i && !go) ? mem_cnt + 1 : 0;
    mem_ack_i <= go;
    mem_rdata_i <= go ? mem_byte : ~mem_byte;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    close_out;
  end

  initial
  begin
    void'($urandom(98302));
    port_a_pins_i <= 6'($urandom);
    port_b_pins_i <= 8'($urandom);
    port_c_pins_i <= 8'($urandom);
    rst_seq;
    rd(5'h03, 8'h18);
    for (int i = 1; i < 32; i++)
      if (i != 2 && i != 3)
      begin
        r = 8'($urandom);
        if (i == 12) r[7:6] = 2'b00;
        wr(i[4:0], r);
        e = r & SFB_WR_MASK[i] & SFB_RD_MASK[i];
        if (i == 5) e = {2'b00, port_a_pins_i};
        if (i == 6) e = port_b_pins_i;
        if (i == 7) e = port_c_pins_i;
        if (i >= 5 && i <= 7) lat = {r, lat[23:8]};
        rd(i[4:0], e);
      end
    wr(5'h0A, 8'hF5);
    check("pc", pc_o, 0);
    rd(5'h0A, 8'h15);
    wr(5'h02, 8'h34);
    @(posedge core_clk_i);
    check("pc", pc_o, 13'h1534);
    pc_inc_i <= 1;
    @(posedge core_clk_i);
    pc_inc_i <= 0;
    @(posedge core_clk_i);
    check("pc", pc_o, 13'h1535);
    rd(5'h02, 8'h35);
    wr(5'h01, 8'h5A);
    wr(5'h03, 8'h20);
    check("bank", bank_select_o, 1);
    rd(5'h0A, 8'h15);
    rd(5'h03, 8'h38);
    rd(5'h0C, 8'h00);
    wr(5'h01, 8'h77);
    wr(5'h03, 8'h00);
    rd(5'h01, 8'h5A);
    exp_mem = {1'b1, 8'h40, 8'hA5};
    mem_wait = 3;
    wr(5'h04, 8'h40);
    wr(5'h00, 8'hA5);
    exp_mem = {1'b0, 8'h40, 8'h00};
    mem_wait = 0;
    mem_byte = 8'($urandom);
    rd(5'h00, mem_byte);
    wr(5'h04, 8'h00);
    rd(5'h00, 8'h00);
    wr(5'h03, 8'h05);
    wr(5'h0B, 8'hFF);
    wr(5'h0C, 8'h3F);
    watchdog_timeout_i <= 1;
    @(posedge core_clk_i);
    watchdog_timeout_i <= 0;
    @(posedge core_clk_i);
    check("pc", pc_o, 0);
    check("latch", {port_c_latch_o, port_b_latch_o, 2'b00, port_a_latch_o},
      lat & 24'hFF_FF3F);
    rd(5'h01, 8'h5A);
    rd(5'h03, 8'h0D);
    rd(5'h0B, 8'h01);
    rd(5'h0C, 8'h00);
    rd(5'h0A, 8'h00);
    master_clear_pin_n_i <= 0;
    repeat (5) @(posedge core_clk_i);
    master_clear_pin_n_i <= 1;
    repeat (5) @(posedge core_clk_i);
    rd(5'h03, 8'h1D);
    rst_seq;
    rd(5'h01, 8'h00);
    check("latch", {port_c_latch_o, port_b_latch_o, 2'b00, port_a_latch_o},
      0);
    rd(5'h03, 8'h18);
    close_out;
  end
endmodule
